// ==== hw/tws_pkg.sv ====
/*
 two-wire slave transmitter: shared constants, status codes and state encoding.
 assumes nothing of its surroundings; imported whole by tws_slave_tx and the bench.
*/
package tws_pkg;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam int BUF_DEPTH = 2;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // status codes
   localparam logic [7:0] CODE_OWN_READ = 8'hA8;
   localparam logic [7:0] CODE_ARB_READ = 8'hB0;
   localparam logic [7:0] CODE_DATA_ACK = 8'hB8;
   localparam logic [7:0] CODE_DATA_NACK = 8'hC0;
   localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
   localparam logic [7:0] CODE_NO_INFO = 8'hF8;
   localparam logic [7:0] CODE_BUS_ERR = 8'h00;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic READ_DIR = 1'b1;
   localparam logic PIN_LOW = 1'b0;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK = 7'h04,
      ST_WAIT = 7'h08,
      ST_TX = 7'h10,
      ST_RACK = 7'h20,
      ST_IGN = 7'h40
   } tws_state_e;
   localparam tws_state_e ST_ERR_CODE = ST_IGN;
endpackage : tws_pkg

// ==== hw/tws_tx_buf.sv ====
/*
 small valid/ready buffer holding bytes waiting to go out on the bus.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_tx_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [WIDTH-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   wire push_w = in_valid_in & in_ready_out;
   wire pop_w = out_valid_out & out_ready_in;
   assign in_ready_out = (cnt_q != FULL_CNT);
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : nxt
   always_ff @(posedge ref_clk_in) begin
      if (push_w) begin
         mem_q[wr_q] <= in_data_in;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push_w) wr_q <= nxt(wr_q);
         if (pop_w) rd_q <= nxt(rd_q);
         cnt_q <= cnt_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
      end
   end
endmodule : tws_tx_buf
`default_nettype wire

// ==== hw/tws_slave_tx.sv ====
/*
 two-wire slave transmitter with no-information and bus-error status.
 assumes scl/sda pins are open drain and resolved outside; control bits are
 plain ports; irq_clear_in and stop_request_in act on ctrl_wr_in, the enables are read live; one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tx import tws_pkg::*; (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe_n_out,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic iface_enable_in,
   input wire logic ack_enable_in,
   input wire logic general_call_enable_in,
   input wire logic [ADDR_W-1:0] own_addr_in,
   input wire logic ctrl_wr_in,
   input wire logic irq_clear_in,
   input wire logic stop_request_in,
   input wire logic arb_lost_in,
   input wire logic [BYTE_W-1:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic iface_irq_flag_out,
   output logic [BYTE_W-1:0] status_code_out,
   output logic stop_request_out
);
   tws_state_e st_q, st_d;
   logic scl_s1_q, scl_s2_q, scl_p_q;
   logic sda_s1_q, sda_s2_q, sda_p_q;
   logic [2:0] cnt_q, cnt_d;
   logic [BYTE_W-1:0] sh_q, sh_d;
   logic [BYTE_W-1:0] code_q, code_d;
   logic pull_q, pull_d;
   logic last_q, last_d;
   logic nack_q, nack_d;
   logic wait_p_q;
   logic irq_q, arb_q, stop_q, err_q;
   logic irq_set, pop;
   logic [BYTE_W-1:0] buf_data;
   logic buf_valid;

   // the second stage of each synchroniser and the delayed copy behind it feed the edge logic
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      end else begin
         {scl_s1_q, scl_s2_q, scl_p_q} <= {scl_in, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_p_q} <= {sda_in, sda_s1_q, sda_s2_q};
      end
   end

   wire scl_rise = scl_s2_q & ~scl_p_q;
   wire scl_fall = ~scl_s2_q & scl_p_q;
   wire scl_high = scl_s2_q & scl_p_q;
   wire start_w = scl_high & sda_p_q & ~sda_s2_q;
   wire stop_w = scl_high & ~sda_p_q & sda_s2_q;
   wire [BYTE_W-1:0] addr_byte = {sh_q[BYTE_W-2:0], sda_s2_q};
   wire own_hit = addr_byte[BYTE_W-1:1] == own_addr_in;
   wire gc_hit = general_call_enable_in & (addr_byte[BYTE_W-1:1] == GEN_CALL_ADDR);
   // ack_enable is read live, so it takes effect on the next address
   wire match_w = ack_enable_in & (own_hit | gc_hit) & (addr_byte[0] == READ_DIR);
   wire in_frame = (st_q == ST_ADDR && cnt_q != BIT_FIRST) || st_q == ST_ACK
      || st_q == ST_TX || st_q == ST_RACK;
   wire bus_err_w = iface_enable_in & (start_w | stop_w) & in_frame;
   wire irq_clr_w = ctrl_wr_in & irq_clear_in;
   wire recover_w = err_q & irq_clr_w & stop_request_in;

   tws_tx_buf #(
      .WIDTH(BYTE_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_data_in(tx_data_in),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .out_data_out(buf_data),
      .out_valid_out(buf_valid),
      .out_ready_in(pop)
   );

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      code_d = code_q;
      pull_d = pull_q;
      last_d = last_q;
      nack_d = nack_q;
      irq_set = 1'b0;
      pop = 1'b0;
      case (st_q)
         ST_IDLE: begin
            pull_d = 1'b0;
            if (start_w) begin
               st_d = ST_ADDR;
               cnt_d = BIT_FIRST;
            end
         end
         ST_ADDR: begin
            if (stop_w) begin
               st_d = ST_IDLE;
            end else if (scl_rise) begin
               sh_d = addr_byte;
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == BIT_LAST) st_d = match_w ? ST_ACK : ST_IGN;
            end
         end
         ST_ACK: begin
            if (scl_fall && !pull_q) begin
               pull_d = 1'b1;
            end else if (scl_fall) begin
               pull_d = 1'b0;
               irq_set = 1'b1;
               code_d = arb_q ? CODE_ARB_READ : CODE_OWN_READ;
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // waits for both the flag clear and a byte, so an empty buffer stretches too
            if (!irq_q && buf_valid) begin
               sh_d = buf_data;
               pop = 1'b1;
               pull_d = ~buf_data[BYTE_W-1];
               last_d = ~ack_enable_in;
               cnt_d = BIT_FIRST;
               st_d = ST_TX;
            end
         end
         ST_TX: begin
            if (scl_fall) begin
               cnt_d = cnt_q + 3'h1;
               sh_d = {sh_q[BYTE_W-2:0], 1'b0};
               pull_d = (cnt_q == BIT_LAST) ? 1'b0 : ~sh_q[BYTE_W-2];
               if (cnt_q == BIT_LAST) st_d = ST_RACK;
            end
         end
         ST_RACK: begin
            if (scl_rise) nack_d = sda_s2_q;
            if (scl_fall) begin
               irq_set = 1'b1;
               if (last_q) begin
                  code_d = nack_q ? CODE_DATA_NACK : CODE_LAST_ACK;
                  st_d = ST_IGN;
               end else if (nack_q) begin
                  code_d = CODE_DATA_NACK;
                  st_d = ST_IGN;
               end else begin
                  code_d = CODE_DATA_ACK;
                  st_d = ST_WAIT;
               end
            end
         end
         ST_IGN: begin
            pull_d = 1'b0;
            if (err_q && !recover_w) begin
               st_d = ST_IGN;
            end else if (start_w) begin
               st_d = ST_ADDR;
               cnt_d = BIT_FIRST;
            end else if (stop_w || recover_w) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
            pull_d = 1'b0;
         end
      endcase
      if (bus_err_w) begin
         st_d = ST_ERR_CODE;
         pull_d = 1'b0;
         irq_set = 1'b1;
         code_d = CODE_BUS_ERR;
      end
      if (!iface_enable_in) begin
         st_d = ST_IDLE;
         pull_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q <= ST_IDLE;
         cnt_q <= BIT_FIRST;
         sh_q <= '0;
         code_q <= CODE_NO_INFO;
         {pull_q, last_q, nack_q, wait_p_q} <= 4'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         code_q <= code_d;
         {pull_q, last_q, nack_q, wait_p_q} <= {pull_d, last_d, nack_d, st_q == ST_WAIT};
      end
   end

   // set beats a simultaneous software clear
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         {irq_q, arb_q, stop_q, err_q} <= 4'h0;
      end else begin
         irq_q <= irq_set | (irq_q & ~irq_clr_w);
         arb_q <= arb_lost_in | (arb_q & ~irq_set);
         stop_q <= recover_w ? 1'b0 : (ctrl_wr_in ? stop_request_in : stop_q);
         err_q <= bus_err_w | (err_q & ~recover_w);
      end
   end

   assign iface_irq_flag_out = irq_q;
   assign status_code_out = irq_q ? code_q : CODE_NO_INFO;
   assign stop_request_out = stop_q;
   assign sda_out = PIN_LOW;
   assign scl_out = PIN_LOW;
   // recovery leaves both lines released; no stop is ever driven
   assign sda_oe_n_out = ~pull_q;
   // clock stays low one cycle past the byte load, so sda never moves while scl is high
   assign scl_oe_n_out = ~(st_q == ST_WAIT || wait_p_q);

   sequence s_data_acked;
      st_q == ST_RACK && scl_fall && !last_q && !nack_q;
   endsequence
   sequence s_addr_done;
      st_q == ST_ACK && scl_fall && pull_q && !bus_err_w && iface_enable_in;
   endsequence

   no_info_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !irq_q |-> status_code_out == CODE_NO_INFO) else $error("status not no-info");
   flag_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      irq_q && irq_clr_w && !irq_set |=> !irq_q) else $error("flag not cleared");
   addr_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_addr_done |=> irq_q && (status_code_out == CODE_OWN_READ
      || status_code_out == CODE_ARB_READ)) else $error("address flag missing");
   data_ack_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_data_acked ##0 (iface_enable_in && !bus_err_w)
      |=> irq_q && code_q == CODE_DATA_ACK && st_q == ST_WAIT) else $error("bad ack code");
   bus_err_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      bus_err_w |=> irq_q && status_code_out == CODE_BUS_ERR) else $error("bus error missed");
   recover_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      recover_w && iface_enable_in |=> st_q == ST_IDLE && !stop_request_out)
      else $error("recovery failed");
   err_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      err_q |-> sda_oe_n_out && scl_oe_n_out) else $error("line driven in error");
   ign_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      st_q == ST_IGN |-> sda_oe_n_out) else $error("data driven when ignored");
   ack_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(st_q == ST_ACK) |-> $past(ack_enable_in)) else $error("acked while disabled");
   stretch_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      st_q == ST_WAIT && irq_q |-> !scl_oe_n_out) else $error("clock not stretched");
   load_setup_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(st_q == ST_WAIT) |-> !scl_oe_n_out) else $error("clock released with data");
endmodule : tws_slave_tx
`default_nettype wire

// ==== bench/tws_master_model.sv ====
/* bus master receiver model for the two-wire slave transmitter bench.
 assumes the bench resolves both wires with pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
   input wire logic clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_low_out,
   output logic sda_low_out,
   output logic [7:0] rx_byte_out,
   output logic rx_stb_out
);
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
      rx_byte_out = 8'h00;
      rx_stb_out = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask : w
   // the slave may stretch, so wait on the wire, not on a fixed time
   task automatic rise;
      int n;
      n = 0;
      scl_low_out <= 1'b0;
      while (scl_in !== 1'b1 && n < 4000) begin
         @(posedge clk_in);
         n++;
      end
   endtask : rise
   // 320 ns bit; long low phase covers the slave's sync delay
   task automatic bit_io(input logic v, output logic r);
      w(2);
      sda_low_out <= ~v;
      w(3);
      rise;
      w(1);
      r = sda_in;
      w(1);
      scl_low_out <= 1'b1;
   endtask : bit_io
   task automatic start_c;
      w(2);
      sda_low_out <= 1'b1;
      w(2);
      scl_low_out <= 1'b1;
   endtask : start_c
   task automatic stop_c;
      w(2);
      sda_low_out <= 1'b1;
      w(2);
      rise;
      w(2);
      sda_low_out <= 1'b0;
      w(4);
   endtask : stop_c
   task automatic byte_w(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : byte_w
   task automatic byte_r(input logic ack);
      logic [7:0] b;
      logic r;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         bit_io(1'b1, r);
         b = {b[6:0], r};
      end
      rx_byte_out <= b;
      rx_stb_out <= 1'b1;
      w(1);
      rx_stb_out <= 1'b0;
      bit_io(~ack, r);
   endtask : byte_r
endmodule : tws_master_model
`default_nettype wire

// ==== bench/tb.sv ====
/* self-checking bench for tws_slave_tx with a master model on the bus.
 assumes only the 25 MHz bench clock; software is played by tasks. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tws_pkg::*;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, iface_enable_in = 1'b1, ack_enable_in = 1'b1;
   logic general_call_enable_in = 1'b0, ctrl_wr_in = 1'b0, irq_clear_in = 1'b0;
   logic stop_request_in = 1'b0, arb_lost_in = 1'b0, tx_valid_in = 1'b0, flag_prev = 1'b0;
   logic [ADDR_W-1:0] own_addr_in = 7'h00;
   logic [BYTE_W-1:0] tx_data_in = 8'h00;
   logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, tx_ready_out, stop_request_out;
   logic iface_irq_flag_out, m_scl_low, m_sda_low, rx_stb, ack;
   logic [BYTE_W-1:0] status_code_out, rx_byte, want;
   logic [7:0] exp_code[$];
   logic [7:0] exp_byte[$];
   int miscompares = 0;
   int checked = 0;
   wire scl_in = ~m_scl_low & (scl_oe_n_out | scl_out);
   wire sda_in = ~m_sda_low & (sda_oe_n_out | sda_out);
   tws_slave_tx i_tws_slave_tx (.*);
   tws_master_model m (.clk_in(ref_clk_in), .scl_in(scl_in), .sda_in(sda_in),
      .scl_low_out(m_scl_low), .sda_low_out(m_sda_low), .rx_byte_out(rx_byte),
      .rx_stb_out(rx_stb));
   always #20 ref_clk_in = ~ref_clk_in;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // results are taken in the order the stimulus queued them
   always @(posedge ref_clk_in) begin
      if (iface_irq_flag_out === 1'b1 && flag_prev !== 1'b1) begin
         want = exp_code.size() ? exp_code.pop_front() : 8'hXX;
         check(status_code_out, want);
      end
      if (rx_stb === 1'b1) begin
         want = exp_byte.size() ? exp_byte.pop_front() : 8'hXX;
         check(rx_byte, want);
      end
      flag_prev <= iface_irq_flag_out;
   end
   task automatic ctrl(input logic c, input logic s);
      @(posedge ref_clk_in);
      ctrl_wr_in <= 1'b1;
      irq_clear_in <= c;
      stop_request_in <= s;
      @(posedge ref_clk_in);
      ctrl_wr_in <= 1'b0;
      #1;
   endtask : ctrl
   task automatic push(input logic [7:0] b);
      @(posedge ref_clk_in);
      tx_data_in <= b;
      tx_valid_in <= 1'b1;
      @(posedge ref_clk_in);
      while (tx_ready_out !== 1'b1) @(posedge ref_clk_in);
      tx_valid_in <= 1'b0;
      #1;
   endtask : push
   task automatic wait_flag;
      for (int n = 0; n < 3000 && iface_irq_flag_out !== 1'b1; n++) @(posedge ref_clk_in);
      #1;
      check(iface_irq_flag_out, 1'b1);
   endtask : wait_flag
   task automatic mstart(input logic [7:0] a, input logic exp_ack);
      m.start_c;
      m.byte_w(a, ack);
      check(ack, exp_ack);
   endtask : mstart
   task automatic probe(input logic [7:0] a);
      mstart(a, 1'b0);
      m.stop_c;
      check(iface_irq_flag_out, 1'b0);
   endtask : probe
   // one read of a single byte ended by the master's not-acknowledge
   task automatic txn(input logic [7:0] a, input logic [7:0] c);
      logic [7:0] b;
      b = 8'($urandom);
      exp_code.push_back(c);
      exp_code.push_back(CODE_DATA_NACK);
      exp_byte.push_back(b);
      push(b);
      fork
         begin
            mstart(a, 1'b1);
            m.byte_r(1'b0);
            m.stop_c;
         end
         begin
            wait_flag;
            ctrl(1'b1, 1'b0);
            wait_flag;
            ctrl(1'b1, 1'b0);
         end
      join
   endtask : txn
   initial begin
      #1000000;
      miscompares++;
      finish_test;
   end
   initial begin
      logic [7:0] b0;
      logic [7:0] b1;
      void'($urandom(32'hE784));
      own_addr_in = 7'h08 + 7'($urandom % 112);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      check({iface_irq_flag_out, scl_oe_n_out, sda_oe_n_out, tx_ready_out}, 8'h07);
      check(status_code_out, CODE_NO_INFO);
      exp_code = '{CODE_OWN_READ, CODE_DATA_ACK, CODE_LAST_ACK};
      exp_byte = '{b0, b1, 8'hFF};
      push(b0);
      push(b1);
      check(tx_ready_out, 1'b0);
      fork
         begin
            mstart({own_addr_in, READ_DIR}, 1'b1);
            m.byte_r(1'b1);
            m.byte_r(1'b1);
            m.byte_r(1'b0);
            m.stop_c;
         end
         begin
            wait_flag;
            check(scl_oe_n_out, PIN_LOW);
            ctrl(1'b0, 1'b0);
            check(iface_irq_flag_out, 1'b1);
            ctrl(1'b1, 1'b0);
            check(status_code_out, CODE_NO_INFO);
            wait_flag;
            @(posedge ref_clk_in);
            ack_enable_in <= 1'b0;
            ctrl(1'b1, 1'b0);
            wait_flag;
            ctrl(1'b1, 1'b0);
         end
      join
      probe({own_addr_in, READ_DIR});
      @(posedge ref_clk_in);
      ack_enable_in <= 1'b1;
      probe({own_addr_in, ~READ_DIR});
      probe({own_addr_in ^ 7'h01, READ_DIR});
      probe({GEN_CALL_ADDR, READ_DIR});
      @(posedge ref_clk_in);
      iface_enable_in <= 1'b0;
      probe({own_addr_in, READ_DIR});
      @(posedge ref_clk_in);
      iface_enable_in <= 1'b1;
      txn({own_addr_in, READ_DIR}, CODE_OWN_READ);
      @(posedge ref_clk_in);
      general_call_enable_in <= 1'b1;
      txn({GEN_CALL_ADDR, READ_DIR}, CODE_OWN_READ);
      // a stop after three address bits is a framing fault
      exp_code.push_back(CODE_BUS_ERR);
      m.start_c;
      repeat (3) m.bit_io(1'b1, ack);
      m.stop_c;
      wait_flag;
      check({scl_oe_n_out, sda_oe_n_out}, 8'h03);
      ctrl(1'b1, 1'b1);
      check({iface_irq_flag_out, stop_request_out, scl_oe_n_out}, 8'h01);
      @(posedge ref_clk_in);
      arb_lost_in <= 1'b1;
      @(posedge ref_clk_in);
      arb_lost_in <= 1'b0;
      txn({own_addr_in, READ_DIR}, CODE_ARB_READ);
      check(8'(exp_code.size() + exp_byte.size()), 8'h00);
      finish_test;
   end
endmodule : tb
`default_nettype wire
